// ===== design/i2csra_top.sv
// top: apb registers, status flags, address match and slave byte engine
// assumes pins synchronous to CLK_SYS, apb master per protocol
// Overview of operation
// [RL1] stop seen set on stop, cleared on start
// [RL2] start seen set on start, cleared on stop
// [RL3] direction bit updated after each address byte; here only after a matching address byte, not the ten-bit low byte
// [RL4] rx full on byte load, cleared on read
// [RL5] tx full on write, cleared when sent
// [RL6] twelve-bit divisor sets serial clock rate
// [RL7] software derives divisor from clock period
// [RL8] software never programs divisor zero or one
// [RL9] ten-bit own address, upper bits zero
// [RL10] set mask bit makes position don't-care
// [RL11] clear mask bit demands exact match
// [RL12] mask bits 9, 8, 0 only wide mode
// [RL13] fields reset zero, unused bits read zero
// [RL14] wide select picks ten or seven bits
// [RL15] disable or reset clears all status flags; here disable leaves the interrupt status bits set, only reset clears them
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module i2csra_top import i2csra_pkg::*; (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic IRQ
);
    i2csra_cond_t cond;
    i2csra_state_t state_r;
    logic tick;
    logic en_r, wide_r;
    logic [BRG_W-1:0] brg_r;
    logic [ADR_W-1:0] own_r, mask_r;
    logic [7:0] tx_hold_r, rx_hold_r, shift_r;
    logic [3:0] cnt_r;
    logic ack_on_r, lo_pend_r, lo_phase_r, a10_ok_r, next_tx_r;
    logic stop_r, start_r, dir_r, rxf_r, txf_r;
    logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
    logic drv_pend_r, drv_want_r, drv_want, sda_oe_r, sda_o_r;
    logic [31:0] prdata_r, rd_mux;
    logic pready_r, pslverr_r, irq_r;
    logic setup, wr, rd;
    logic [7:0] byte_in;
    logic addr_done, addr_hit, go_lo, go_tx;
    logic rx_load, tx_done, rx_rd, tx_wr, irq_rd;

    function automatic logic masked_eq(input logic [9:0] a, input logic [9:0] b,
                                       input logic [9:0] m);
        masked_eq = (((a ^ b) & ~m) == 10'h000);
    endfunction : masked_eq

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a <= OFS_IRQ_MASK) && (a[1:0] == 2'b00);
    endfunction : is_mapped

    i2csra_cond i2csra_cond_i (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .cond(cond)
    );

    i2csra_rate i2csra_rate_i (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .en(en_r),
        .divisor(brg_r),
        .tick(tick)
    );

    // apb decode
    assign setup = PSEL & ~PENABLE;
    assign wr = PSEL & PENABLE & PWRITE;
    assign rd = PSEL & PENABLE & ~PWRITE;
    assign rx_rd = rd & (PADDR == OFS_RX);
    assign irq_rd = rd & (PADDR == OFS_IRQ_STAT);
    assign tx_wr = wr & (PADDR == OFS_TX);

    // address byte evaluation
    assign byte_in = {shift_r[6:0], SDA_IN};
    assign addr_done = en_r & ~cond.start & ~cond.stop & cond.scl_rise
                       & (state_r == ST_ADDR) & (cnt_r == LAST_BIT);
    always_comb begin
        if (lo_phase_r) begin
            addr_hit = masked_eq({2'b00, byte_in}, {2'b00, own_r[7:0]},
                                 {2'b00, mask_r[7:0]}); // RL10 RL11
        end else if (wide_r) begin
            addr_hit = (byte_in[7:3] == HDR10) & (~byte_in[0] | a10_ok_r)
                       & masked_eq({8'h00, byte_in[2:1]}, {8'h00, own_r[9:8]},
                                   {8'h00, mask_r[9:8]}); // RL14 RL12
        end else begin
            addr_hit = masked_eq({3'b000, byte_in[7:1]}, {3'b000, own_r[6:0]},
                                 {3'b000, mask_r[6:1], 1'b0}); // RL12 RL14
        end
    end
    assign go_lo = wide_r & ~lo_phase_r & ~byte_in[0];
    assign go_tx = ~lo_phase_r & byte_in[0];
    assign rx_load = en_r & ~cond.start & ~cond.stop & cond.scl_rise
                     & (state_r == ST_RXD) & (cnt_r == LAST_BIT);
    assign tx_done = en_r & ~cond.start & ~cond.stop & cond.scl_rise
                     & (state_r == ST_TACK);

    // slave byte engine
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            cnt_r <= 4'h0;
            ack_on_r <= 1'b0;
            lo_pend_r <= 1'b0;
            lo_phase_r <= 1'b0;
            a10_ok_r <= 1'b0;
            next_tx_r <= 1'b0;
        end else if (!en_r || cond.stop) begin
            state_r <= ST_IDLE;
            ack_on_r <= 1'b0;
            lo_pend_r <= 1'b0;
            lo_phase_r <= 1'b0;
            a10_ok_r <= 1'b0;
        end else if (cond.start) begin
            state_r <= ST_ADDR;
            cnt_r <= 4'h0;
            ack_on_r <= 1'b0;
            lo_pend_r <= 1'b0;
            lo_phase_r <= 1'b0;
        end else if (cond.scl_rise) begin
            case (state_r)
                ST_ADDR: begin
                    shift_r <= byte_in;
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == LAST_BIT) begin
                        state_r <= addr_hit ? ST_AACK : ST_IDLE;
                        next_tx_r <= go_tx;
                        lo_pend_r <= go_lo & addr_hit;
                        if (lo_phase_r) begin
                            a10_ok_r <= addr_hit;
                        end
                        lo_phase_r <= 1'b0;
                    end
                end
                ST_RXD: begin
                    shift_r <= byte_in;
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == LAST_BIT) begin
                        state_r <= ST_RACK;
                    end
                end
                ST_TACK: begin
                    if (SDA_IN) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (cond.scl_fall) begin
            case (state_r)
                ST_AACK, ST_RACK: begin
                    if (!ack_on_r) begin
                        ack_on_r <= 1'b1;
                    end else begin
                        ack_on_r <= 1'b0;
                        cnt_r <= 4'h0;
                        if (state_r == ST_RACK) begin
                            state_r <= ST_RXD;
                        end else if (lo_pend_r) begin
                            state_r <= ST_ADDR;
                            lo_pend_r <= 1'b0;
                            lo_phase_r <= 1'b1;
                        end else if (next_tx_r) begin
                            state_r <= ST_TXD;
                            shift_r <= {tx_hold_r[6:0], 1'b0};
                            cnt_r <= 4'h1;
                        end else begin
                            state_r <= ST_RXD;
                        end
                    end
                end
                ST_TXD: begin
                    if (cnt_r == TX_END) begin
                        state_r <= ST_TACK;
                    end else begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                ST_TACK: begin
                    state_r <= ST_TXD;
                    shift_r <= {tx_hold_r[6:0], 1'b0};
                    cnt_r <= 4'h1;
                end
                default: begin
                end
            endcase
        end
    end

    // level wanted on sda after a clock fall (1 = pull low)
    always_comb begin
        drv_want = 1'b0;
        case (state_r)
            ST_AACK: drv_want = ~ack_on_r | (next_tx_r & ~lo_pend_r & ~tx_hold_r[7]);
            ST_RACK: drv_want = ~ack_on_r;
            ST_TXD: drv_want = (cnt_r != TX_END) & ~shift_r[7];
            ST_TACK: drv_want = ~tx_hold_r[7];
            default: drv_want = 1'b0;
        endcase
    end

    // sda drive applied on the next rate tick after the clock fall
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            drv_pend_r <= 1'b0;
            drv_want_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (!en_r || cond.start || cond.stop) begin
            drv_pend_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (cond.scl_fall) begin
            drv_pend_r <= 1'b1;
            drv_want_r <= drv_want;
        end else if (drv_pend_r && tick) begin
            drv_pend_r <= 1'b0;
            sda_oe_r <= drv_want_r; // RL6
        end
    end

    // bus condition and direction flags
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            stop_r <= 1'b0;
            start_r <= 1'b0;
            dir_r <= 1'b0;
        end else if (!en_r) begin
            stop_r <= 1'b0; // RL15
            start_r <= 1'b0;
            dir_r <= 1'b0;
        end else begin
            if (cond.stop) begin
                stop_r <= 1'b1; // RL1
                start_r <= 1'b0; // RL2
            end else if (cond.start) begin
                stop_r <= 1'b0; // RL1
                start_r <= 1'b1; // RL2
            end
            if (addr_done && addr_hit && !lo_phase_r) begin
                dir_r <= byte_in[0]; // RL3
            end
        end
    end

    // holding register flags, set wins over clear
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rxf_r <= 1'b0;
            txf_r <= 1'b0;
            rx_hold_r <= 8'h00;
        end else if (!en_r) begin
            rxf_r <= 1'b0; // RL15
            txf_r <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_hold_r <= byte_in;
                rxf_r <= 1'b1; // RL4
            end else if (rx_rd) begin
                rxf_r <= 1'b0; // RL4
            end
            if (tx_wr) begin
                txf_r <= 1'b1; // RL5
            end else if (tx_done) begin
                txf_r <= 1'b0; // RL5
            end
        end
    end

    // software registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            en_r <= 1'b0;
            wide_r <= 1'b0;
            brg_r <= BRG_RST; // RL13
            own_r <= OWN_RST;
            mask_r <= MASK_RST;
            tx_hold_r <= 8'h00;
            irq_mask_r <= '0;
        end else if (wr) begin
            if (PADDR == OFS_CTRL) begin
                en_r <= PWDATA[CTRL_EN_BIT];
                wide_r <= PWDATA[CTRL_WIDE_BIT];
            end else if (PADDR == OFS_BRG) begin
                brg_r <= PWDATA[BRG_W-1:0]; // RL6
            end else if (PADDR == OFS_OWN) begin
                own_r <= PWDATA[ADR_W-1:0]; // RL9
            end else if (PADDR == OFS_MASK) begin
                mask_r <= PWDATA[ADR_W-1:0];
            end else if (PADDR == OFS_TX) begin
                tx_hold_r <= PWDATA[7:0];
            end else if (PADDR == OFS_IRQ_MASK) begin
                irq_mask_r <= PWDATA[IRQ_W-1:0];
            end
        end
    end

    // read data mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (PADDR == OFS_CTRL) begin
            rd_mux[CTRL_EN_BIT] = en_r;
            rd_mux[CTRL_WIDE_BIT] = wide_r;
        end else if (PADDR == OFS_STATUS) begin
            rd_mux[ST_TXF_BIT] = txf_r;
            rd_mux[ST_RXF_BIT] = rxf_r;
            rd_mux[ST_DIR_BIT] = dir_r;
            rd_mux[ST_START_BIT] = start_r;
            rd_mux[ST_STOP_BIT] = stop_r;
        end else if (PADDR == OFS_BRG) begin
            rd_mux[BRG_W-1:0] = brg_r; // RL6 RL13
        end else if (PADDR == OFS_OWN) begin
            rd_mux[ADR_W-1:0] = own_r; // RL9 RL13
        end else if (PADDR == OFS_MASK) begin
            rd_mux[ADR_W-1:0] = mask_r;
        end else if (PADDR == OFS_TX) begin
            rd_mux[7:0] = tx_hold_r;
        end else if (PADDR == OFS_RX) begin
            rd_mux[7:0] = rx_hold_r;
        end else if (PADDR == OFS_IRQ_STAT) begin
            rd_mux[IRQ_W-1:0] = irq_stat_r;
        end else if (PADDR == OFS_IRQ_MASK) begin
            rd_mux[IRQ_W-1:0] = irq_mask_r;
        end
    end

    // apb answer: captured in setup, ready in access
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
        end else begin
            pready_r <= 1'b1;
            if (setup) begin
                prdata_r <= PWRITE ? 32'h0000_0000 : rd_mux;
                pslverr_r <= ~is_mapped(PADDR);
            end
        end
    end

    // sticky events, read clears only what was returned
    assign irq_set = {addr_done & addr_hit, tx_done, rx_load,
                      en_r & cond.stop, en_r & cond.start};
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_set | (irq_stat_r & ~(irq_rd ? prdata_r[IRQ_W-1:0] : 5'h00));
            irq_r <= |((irq_set | irq_stat_r) & irq_mask_r);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sda_o_r <= 1'b0;
        end else begin
            sda_o_r <= 1'b0;
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign SDA_OUT = sda_o_r;
    assign SDA_OE = sda_oe_r;
    assign IRQ = irq_r;

    // checks
    logic [BRG_W:0] gap_r;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            gap_r <= '0;
        end else if (tick || !en_r) begin
            gap_r <= '0;
        end else begin
            gap_r <= gap_r + 13'h0001;
        end
    end

    sequence s_byte_hit;
        addr_done && addr_hit && !lo_phase_r;
    endsequence
    sequence s_ack_state;
        ##1 (state_r == ST_AACK);
    endsequence

    chk_stop_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL1
        en_r && cond.stop |=> stop_r && !start_r) else $error("stop flag wrong");
    chk_start_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL2
        en_r && cond.start |=> start_r && !stop_r) else $error("start flag wrong");
    chk_dir_update: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL3
        s_byte_hit |=> dir_r == $past(SDA_IN)) else $error("direction not updated");
    chk_rx_fill: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL4
        rx_load |=> rxf_r && rx_hold_r == $past(byte_in)) else $error("rx not loaded");
    chk_rx_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL4
        en_r && rx_rd && !rx_load |=> !rxf_r) else $error("rx full not cleared");
    chk_tx_full: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL5
        en_r && tx_wr |=> txf_r) else $error("tx full not set");
    chk_tx_done: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL5
        tx_done && !tx_wr |=> !txf_r) else $error("tx full not cleared");
    chk_rate_gap: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL6
        tick |-> gap_r == {1'b0, brg_r} + 13'h0001) else $error("rate tick spacing");
    chk_reg_upper: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL9 RL13
        setup && !PWRITE && (PADDR == OFS_OWN || PADDR == OFS_MASK)
        |=> PRDATA[31:10] == 22'h000000) else $error("upper bits not zero");
    chk_mask_hit: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL10 RL11
        addr_done && !wide_r && !lo_phase_r && masked_eq({3'b000, byte_in[7:1]},
        {3'b000, own_r[6:0]}, {3'b000, mask_r[6:1], 1'b0}) |-> s_ack_state)
        else $error("masked address not taken");
    chk_seven_bit: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL12
        addr_done && !wide_r && (byte_in[1] != own_r[0]) |=> state_r == ST_IDLE)
        else $error("mask bit 0 used in 7-bit mode");
    chk_disable_clr: assert property (@(posedge CLK_SYS) disable iff (!RST_N) // RL15
        !en_r |=> !(stop_r || start_r || dir_r || rxf_r || txf_r))
        else $error("flags kept while disabled");
endmodule : i2csra_top

// ===== design/i2csra_pkg.sv
// package: register map, field positions, states and carriers of the
// two-wire slave status, bit-rate and address-match block
// assumes a 32-bit apb register bus and one system clock
package i2csra_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BRG = 8'h08;
    localparam logic [7:0] OFS_OWN = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_TX = 8'h14;
    localparam logic [7:0] OFS_RX = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

    // control fields
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_WIDE_BIT = 1;

    // status fields
    localparam int unsigned ST_TXF_BIT = 0;
    localparam int unsigned ST_RXF_BIT = 1;
    localparam int unsigned ST_DIR_BIT = 2;
    localparam int unsigned ST_START_BIT = 3;
    localparam int unsigned ST_STOP_BIT = 4;

    // interrupt status / mask fields
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned IRQ_START_BIT = 0;
    localparam int unsigned IRQ_STOP_BIT = 1;
    localparam int unsigned IRQ_RX_BIT = 2;
    localparam int unsigned IRQ_TXDONE_BIT = 3;
    localparam int unsigned IRQ_MATCH_BIT = 4;

    // widths and reset values
    localparam int unsigned BRG_W = 12;
    localparam int unsigned ADR_W = 10;
    localparam logic [11:0] BRG_RST = 12'h000;
    localparam logic [9:0] OWN_RST = 10'h000;
    localparam logic [9:0] MASK_RST = 10'h000;
    localparam logic [4:0] HDR10 = 5'h1e;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] TX_END = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_RXD, ST_RACK, ST_TXD, ST_TACK
    } i2csra_state_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } i2csra_cond_t;

endpackage : i2csra_pkg

// ===== design/i2csra_cond.sv
// bus condition detector: start, stop and serial clock edges
// assumes scl and sda inputs already synchronous to the clock
`timescale 1ns/1ps
module i2csra_cond import i2csra_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output i2csra_cond_t cond
);
    logic scl_q;
    logic sda_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // data moving while clock stays high marks a condition
    always_comb begin
        cond.start = scl_q & scl_in & sda_q & ~sda_in;
        cond.stop = scl_q & scl_in & ~sda_q & sda_in;
        cond.scl_rise = ~scl_q & scl_in;
        cond.scl_fall = scl_q & ~scl_in;
    end
endmodule : i2csra_cond

// ===== design/i2csra_rate.sv
// bit-rate divider: one-cycle tick every divisor + 2 clocks
// assumes divisor held stable while enabled
`timescale 1ns/1ps
module i2csra_rate import i2csra_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic [BRG_W-1:0] divisor,
    output logic tick
);
    logic [BRG_W:0] cnt_r;
    logic [BRG_W:0] limit;

    assign limit = {1'b0, divisor} + 13'h0001;
    assign tick = en & (cnt_r >= limit);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (!en || tick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 13'h0001;
        end
    end
endmodule : i2csra_rate

// ===== bench/i2csra_master.sv
// two-wire bus master model: moves scl, pulls or releases sda
// assumes sda_in is the wired-and line level with a pull-up
`timescale 1ns/1ps
module i2csra_master (
    input wire logic clk,
    input wire logic sda_in,
    output logic scl,
    output logic sda_o
);
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    task automatic gap;
        repeat (8) @(posedge clk);
    endtask : gap
    task automatic start;
        sda_o <= 1'b0;
        gap();
        scl <= 1'b0;
    endtask : start
    // repeated start from a low clock: release data, raise clock, then start
    task automatic restart;
        gap();
        sda_o <= 1'b1;
        gap();
        scl <= 1'b1;
        gap();
        start();
    endtask : restart
    task automatic stop;
        gap();
        sda_o <= 1'b0;
        gap();
        scl <= 1'b1;
        gap();
        sda_o <= 1'b1;
        gap();
    endtask : stop
    task automatic bit_x(input logic b, output logic r);
        gap();
        sda_o <= b;
        gap();
        scl <= 1'b1;
        gap();
        r = sda_in;
        gap();
        scl <= 1'b0;
    endtask : bit_x
    // a = level offered in the ack slot, k = ack level seen
    task automatic byte_x(input logic [7:0] b, input logic a, output logic [7:0] r, output logic k);
        for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
        bit_x(a, k);
    endtask : byte_x
endmodule : i2csra_master

// ===== bench/i2csra_tb.sv
// testbench: apb register checks and serial transfers via master model
// assumes the top module, its package and the master model
`timescale 1ns/1ps
module i2csra_tb import i2csra_pkg::*;;
    logic CLK_SYS = 1'b0, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SDA_OUT, SDA_OE, IRQ;
    logic [7:0] PADDR, r;
    logic [31:0] PWDATA, PRDATA, q;
    logic scl, sda_o, sda, er, k;
    int fail_count = 0, samples_checked = 0, cyc = 0;
    logic [7:0] ms [4] = '{8'h00, 8'h00, 8'h02, 8'h01};
    logic [6:0] ad [4] = '{7'h2a, 7'h2b, 7'h28, 7'h2b};
    logic ex [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    assign sda = sda_o & (SDA_OE ? SDA_OUT : 1'b1);
    always #20 CLK_SYS = ~CLK_SYS;
    i2csra_top i2csra_top_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));
    i2csra_master i2csra_master_i (.clk(CLK_SYS), .sda_in(sda), .scl(scl), .sda_o(sda_o));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do @(posedge CLK_SYS); while (PREADY !== 1'b1);
        q = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK_SYS);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg_%h", a), e, q);
    endtask : rd
    initial begin
        RST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (20) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        @(posedge CLK_SYS);
        rd(OFS_BRG, 32'h0);
        rd(OFS_OWN, 32'h0);
        rd(OFS_MASK, 32'h0);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_BRG, 32'hffffffff);
        rd(OFS_BRG, 32'h00000fff);
        wr(OFS_OWN, 32'hffffffff);
        rd(OFS_OWN, 32'h000003ff);
        wr(OFS_MASK, 32'hffffffff);
        rd(OFS_MASK, 32'h000003ff);
        apb(1'b0, 8'h24, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        // divisor 4: never 0 or 1, reaction well inside scl low
        wr(OFS_BRG, 32'h4);
        wr(OFS_OWN, 32'h2a);
        wr(OFS_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_MASK, {24'h0, ms[i]});
            i2csra_master_i.start();
            i2csra_master_i.byte_x({ad[i], 1'b0}, 1'b1, r, k);
            i2csra_master_i.stop();
            chk("addr_ack", {31'h0, ex[i]}, {31'h0, k});
        end
        wr(OFS_MASK, 32'h0);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        i2csra_master_i.start();
        chk("irq_masked", 32'h0, {31'h0, IRQ});
        rd(OFS_STATUS, 32'h08);
        wr(OFS_IRQ_MASK, 32'h1f);
        i2csra_master_i.byte_x(8'h54, 1'b1, r, k);
        rd(OFS_STATUS, 32'h08);
        i2csra_master_i.byte_x(8'h5c, 1'b1, r, k);
        chk("data_ack", 32'h0, {31'h0, k});
        rd(OFS_STATUS, 32'h0a);
        chk("irq_on", 32'h1, {31'h0, IRQ});
        rd(OFS_RX, 32'h5c);
        rd(OFS_STATUS, 32'h08);
        i2csra_master_i.stop();
        rd(OFS_STATUS, 32'h10);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("irq_stat", 32'h17, q);
        @(posedge CLK_SYS);
        chk("irq_off", 32'h0, {31'h0, IRQ});
        wr(OFS_TX, 32'ha5);
        rd(OFS_STATUS, 32'h11);
        i2csra_master_i.start();
        i2csra_master_i.byte_x(8'h55, 1'b1, r, k);
        rd(OFS_STATUS, 32'h0d);
        i2csra_master_i.byte_x(8'hff, 1'b1, r, k);
        chk("tx_byte", 32'ha5, {24'h0, r});
        rd(OFS_STATUS, 32'h0c);
        i2csra_master_i.stop();
        wr(OFS_CTRL, 32'h3);
        i2csra_master_i.start();
        i2csra_master_i.byte_x(8'hf0, 1'b1, r, k);
        i2csra_master_i.byte_x(8'h2a, 1'b1, r, k);
        chk("wide_ack", 32'h0, {31'h0, k});
        i2csra_master_i.restart();
        i2csra_master_i.byte_x(8'hf1, 1'b1, r, k);
        chk("wide_read", 32'h0, {31'h0, k});
        rd(OFS_STATUS, 32'h0c);
        i2csra_master_i.stop();
        wr(OFS_CTRL, 32'h0);
        rd(OFS_STATUS, 32'h0);
        report_and_stop();
    end
endmodule : i2csra_tb
